// ---- src/bkrc_defs.svh ----
// constants of the buck regulator control sequencer
// assumes a 50 MHz core clock and a 3.5 MHz switching tick from the oscillator
`ifndef BKRC_DEFS_SVH
`define BKRC_DEFS_SVH

`define BKRC_CLK_MHZ          50
`define BKRC_REF_START_US     20
`define BKRC_STEP_US          60
`define BKRC_SS_NSTEPS        4
`define BKRC_EARLY_STEPS      2
`define BKRC_OVL_CYCLES       32
`define BKRC_CODE_OFF         4'h0
`define BKRC_ILIM_25          2'h0
`define BKRC_ILIM_40          2'h1
`define BKRC_ILIM_60          2'h2
`define BKRC_ILIM_100         2'h3

`endif

// ---- src/bkrc_pkg.sv ----
// types of the buck regulator control sequencer
// no surroundings assumed
package bkrc_pkg;

	typedef enum logic [2:0] {
		BKRC_OFF,
		BKRC_REF_WAIT,
		BKRC_SOFT_START,
		BKRC_RUN,
		BKRC_THERMAL
	} bkrc_seq_type;

	typedef enum logic [1:0] {
		BKRC_MODE_PWM,
		BKRC_MODE_BURST,
		BKRC_MODE_PASS
	} bkrc_mode_type;

endpackage

// ---- src/bkrc_sequencer.sv ----
// control sequencer of a step-down regulator: select decode, pull-down latch,
// soft-start, mode choice and protection; analog comparators arrive as pins
// and are synchronised; switch_tick is a one-cycle pulse per switching period
`timescale 1ns/1ns
`include "bkrc_defs.svh"

// Overview of operation
// [RULE1] decode four select bits to 15 levels; all low shuts down, any high enables
// [RULE2] codes 0001 to 1111 map ascending 0.80 V to 3.30 V; 0000 is off
// [RULE3] pull-downs engaged while supply below 1.5V or input below high threshold
// [RULE4] once an input went high pull-down stays off until all inputs low together
// [RULE5] host avoids transient 0000 codes and keeps intermediate codes brief
// [RULE6] soft-start begins when code goes from zero to non-zero
// [RULE7] soft-start steps current limit through 25%, 40%, 60%, 100%
// [RULE8] wait 20us reference start, then hold each step 60us, 260us total
// [RULE9] end of soft-start: burst if 90% reached in first two steps, else PWM
// [RULE10] normal operation switches at fixed 3.5MHz with regulating duty cycle
// [RULE11] input near output gives 100% duty pass-through until switching can resume
// [RULE12] load below light-load threshold stops PWM and enters burst mode
// [RULE13] burst until target plus 2.5% or burst limit, idle until target, repeat
// [RULE14] leave burst for PWM when output falls below target minus 2%
// [RULE15] over 15% above target disables drive until 2% below target
// [RULE16] 32 consecutive over-limit switching cycles enter foldback at about 150mA
// [RULE17] foldback held until load below foldback limit, then normal regulation
// [RULE18] above 160C both switches off, switch node high impedance
// [RULE19] after 20C hysteresis drop rerun full soft-start
// [RULE20] hold off regulation during supply lockout with 200mV hysteresis
// [RULE21] lowering level in continuous conduction drives output down, else load discharges
// [RULE22] soft-start timing and overload count use the switching oscillator tick
// [RULE23] select inputs synchronised before decode so enable and level agree
module bkrc_sequencer #(
	parameter int unsigned SW_KHZ   = 3500,
	parameter int unsigned CODE_W   = 4
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [CODE_W-1:0] voltage_select_code,
	input  wire logic              supply_below_1v5,
	input  wire logic              supply_lockout,
	input  wire logic              switch_tick,
	input  wire logic              output_reached_90pct,
	input  wire logic              output_above_target,
	input  wire logic              output_above_burst_top,
	input  wire logic              output_below_exit,
	input  wire logic              output_above_ovp,
	input  wire logic              load_over_limit,
	input  wire logic              load_below_foldback,
	input  wire logic              load_below_light,
	input  wire logic              burst_limit_hit,
	input  wire logic              input_near_output,
	input  wire logic              over_temperature,
	input  wire logic              ccm_active,
	output logic [CODE_W-1:0]      pulldown_enable,
	output logic                   regulator_enable,
	output logic [3:0]             output_level,
	output logic [1:0]             current_limit_step,
	output logic [1:0]             regulation_mode,
	output logic                   light_load_burst_mode,
	output logic                   pwm_drive_enable,
	output logic                   high_side_hold_on,
	output logic                   burst_active,
	output logic                   foldback_active,
	output logic                   switch_node_tristate,
	output logic                   active_discharge,
	output logic                   soft_start_active
);

	// tick counts derived from the switching rate, at least one
	localparam int unsigned REF_TICKS  = (`BKRC_REF_START_US * SW_KHZ + 999) / 1000;
	localparam int unsigned STEP_TICKS = (`BKRC_STEP_US * SW_KHZ + 999) / 1000;
	localparam int unsigned TW         = 10;
	localparam logic [TW-1:0] REF_LAST  = TW'(REF_TICKS - 1);
	localparam logic [TW-1:0] STEP_LAST = TW'(STEP_TICKS - 1);
	localparam logic [5:0]    OVL_LAST  = 6'(`BKRC_OVL_CYCLES - 1);
	localparam logic [1:0]    EARLY_LAST = 2'(`BKRC_EARLY_STEPS - 1);

	localparam int unsigned NS = 14;
	// 4 select bits plus fourteen comparator or flag inputs, all asynchronous;
	// one shared two-stage synchroniser keeps code and flags aligned in time
	logic [CODE_W+NS-1:0] sync1_q;
	logic [CODE_W+NS-1:0] sync2_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {voltage_select_code, supply_below_1v5, supply_lockout, switch_tick,
				output_reached_90pct, output_above_target, output_above_burst_top,
				output_below_exit, output_above_ovp, load_over_limit, load_below_foldback,
				load_below_light, burst_limit_hit, input_near_output,
				over_temperature}; // see [RULE23]
			sync2_q <= sync1_q;
		end
	end

	logic [CODE_W-1:0] code_s;
	logic              s_low_sup;
	logic              s_lock;
	logic              s_tick;
	logic              s_90;
	logic              s_tgt;
	logic              s_btop;
	logic              s_exit;
	logic              s_ovp;
	logic              s_ovl;
	logic              s_fbok;
	logic              s_light;
	logic              s_blim;
	logic              s_near;
	logic              s_hot;
	assign {code_s, s_low_sup, s_lock, s_tick, s_90, s_tgt, s_btop, s_exit, s_ovp,
		s_ovl, s_fbok, s_light, s_blim, s_near, s_hot} = sync2_q;

	// ccm flag passes its own synchroniser
	logic ccm1_q;
	logic ccm2_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ccm1_q <= 1'b0;
			ccm2_q <= 1'b0;
		end else begin
			ccm1_q <= ccm_active;
			ccm2_q <= ccm1_q;
		end
	end

	function automatic logic code_on(input logic [CODE_W-1:0] c);
		code_on = (c != `BKRC_CODE_OFF);
	endfunction

	// off and thermal shutdown both park the power stage
	function automatic logic parked(input bkrc_pkg::bkrc_seq_type s);
		parked = (s == bkrc_pkg::BKRC_OFF) || (s == bkrc_pkg::BKRC_THERMAL);
	endfunction

	logic enabled;
	assign enabled = code_on(code_s); // see [RULE1]

	// pull-down latch and sequencer state
	logic [CODE_W-1:0]       released_q;
	logic [CODE_W-1:0]       released_d;
	logic [CODE_W-1:0]       code_q;
	logic [CODE_W-1:0]       code_d;
	bkrc_pkg::bkrc_seq_type  seq_q;
	bkrc_pkg::bkrc_seq_type  seq_d;
	bkrc_pkg::bkrc_mode_type mode_q;
	bkrc_pkg::bkrc_mode_type mode_d;
	logic [TW-1:0]           tcnt_q;
	logic [TW-1:0]           tcnt_d;
	logic [1:0]              step_q;
	logic [1:0]              step_d;
	logic                    early_q;
	logic                    early_d;
	logic [5:0]              ovl_q;
	logic [5:0]              ovl_d;
	logic                    fold_q;
	logic                    fold_d;
	logic                    ovp_q;
	logic                    ovp_d;
	logic                    idle_q;
	logic                    idle_d;
	logic                    dis_q;
	logic                    dis_d;

	always_comb begin
		released_d = released_q;
		code_d     = code_q;
		seq_d      = seq_q;
		mode_d     = mode_q;
		tcnt_d     = tcnt_q;
		step_d     = step_q;
		early_d    = early_q;
		ovl_d      = ovl_q;
		fold_d     = fold_q;
		ovp_d      = ovp_q;
		idle_d     = idle_q;
		dis_d      = dis_q;

		if (s_low_sup || !enabled)
			released_d = '0; // see [RULE3] [RULE4]
		else
			released_d = released_q | code_s; // see [RULE4]

		// lowering the level: active pull-down only in continuous conduction
		if (enabled && code_q != code_s)
			dis_d = (code_s < code_q) && ccm2_q; // see [RULE21]
		else if (!s_tgt)
			dis_d = 1'b0;
		code_d = code_s; // see [RULE2]

		case (seq_q)
		bkrc_pkg::BKRC_OFF: begin
			if (enabled && !s_lock && !s_hot) begin
				seq_d   = bkrc_pkg::BKRC_REF_WAIT; // see [RULE6] [RULE20]
				tcnt_d  = '0;
				step_d  = `BKRC_ILIM_25;
				early_d = 1'b0;
			end
		end
		bkrc_pkg::BKRC_REF_WAIT: begin
			if (s_tick) begin
				if (tcnt_q == REF_LAST) begin
					seq_d  = bkrc_pkg::BKRC_SOFT_START; // see [RULE8] [RULE22]
					tcnt_d = '0;
				end else
					tcnt_d = tcnt_q + 1'b1;
			end
		end
		bkrc_pkg::BKRC_SOFT_START: begin
			if (s_90 && step_q <= EARLY_LAST)
				early_d = 1'b1; // see [RULE9]
			if (s_tick) begin
				if (tcnt_q == STEP_LAST) begin
					tcnt_d = '0;
					if (step_q == `BKRC_ILIM_100) begin
						seq_d  = bkrc_pkg::BKRC_RUN;
						mode_d = early_q ? bkrc_pkg::BKRC_MODE_BURST
							: bkrc_pkg::BKRC_MODE_PWM; // see [RULE9]
					end else
						step_d = step_q + 1'b1; // see [RULE7]
				end else
					tcnt_d = tcnt_q + 1'b1; // see [RULE22]
			end
		end
		bkrc_pkg::BKRC_RUN: begin
			case (mode_q)
			bkrc_pkg::BKRC_MODE_PWM: begin
				if (s_near)
					mode_d = bkrc_pkg::BKRC_MODE_PASS; // see [RULE11]
				else if (s_light)
					mode_d = bkrc_pkg::BKRC_MODE_BURST; // see [RULE12]
			end
			bkrc_pkg::BKRC_MODE_BURST: begin
				if (s_exit)
					mode_d = bkrc_pkg::BKRC_MODE_PWM; // see [RULE14]
				else if (!idle_q && (s_btop || s_blim))
					idle_d = 1'b1; // see [RULE13]
				else if (idle_q && !s_tgt)
					idle_d = 1'b0; // see [RULE13]
			end
			bkrc_pkg::BKRC_MODE_PASS: begin
				if (!s_near)
					mode_d = bkrc_pkg::BKRC_MODE_PWM; // see [RULE11]
			end
			default: mode_d = bkrc_pkg::BKRC_MODE_PWM;
			endcase
			if (mode_d != bkrc_pkg::BKRC_MODE_BURST)
				idle_d = 1'b0;
		end
		bkrc_pkg::BKRC_THERMAL: begin
			// the over-temperature input carries the 20C hysteresis
			if (!s_hot) begin
				seq_d = bkrc_pkg::BKRC_OFF; // see [RULE19]
			end
		end
		default: seq_d = bkrc_pkg::BKRC_OFF;
		endcase

		// over-voltage hysteresis
		if (s_ovp)
			ovp_d = 1'b1; // see [RULE15]
		else if (s_exit)
			ovp_d = 1'b0; // see [RULE15]

		// consecutive overload cycles counted on the switching tick
		if (s_tick && seq_q == bkrc_pkg::BKRC_RUN) begin
			if (!s_ovl)
				ovl_d = '0;
			else if (ovl_q != OVL_LAST)
				ovl_d = ovl_q + 1'b1;
			else
				fold_d = 1'b1; // see [RULE16] [RULE22]
		end
		if (fold_q && s_fbok) begin
			fold_d = 1'b0; // see [RULE17]
			ovl_d  = '0;
		end

		if (s_hot && seq_q != bkrc_pkg::BKRC_OFF)
			seq_d = bkrc_pkg::BKRC_THERMAL; // see [RULE18]
		if ((!enabled || s_lock) && seq_q != bkrc_pkg::BKRC_THERMAL)
			seq_d = bkrc_pkg::BKRC_OFF; // see [RULE1] [RULE20]
		// leaving regulation drops every fault and mode memory except the over-voltage latch
		if (parked(seq_d)) begin
			fold_d = 1'b0;
			ovl_d  = '0;
			mode_d = bkrc_pkg::BKRC_MODE_PWM;
			idle_d = 1'b0;
			dis_d  = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			released_q <= '0;
			code_q     <= `BKRC_CODE_OFF;
			seq_q      <= bkrc_pkg::BKRC_OFF;
			mode_q     <= bkrc_pkg::BKRC_MODE_PWM;
			tcnt_q     <= '0;
			step_q     <= `BKRC_ILIM_25;
			early_q    <= 1'b0;
			ovl_q      <= '0;
			fold_q     <= 1'b0;
			ovp_q      <= 1'b0;
			idle_q     <= 1'b0;
			dis_q      <= 1'b0;
		end else begin
			released_q <= released_d;
			code_q     <= code_d;
			seq_q      <= seq_d;
			mode_q     <= mode_d;
			tcnt_q     <= tcnt_d;
			step_q     <= step_d;
			early_q    <= early_d;
			ovl_q      <= ovl_d;
			fold_q     <= fold_d;
			ovp_q      <= ovp_d;
			idle_q     <= idle_d;
			dis_q      <= dis_d;
		end
	end

	logic running;
	assign running = (seq_q == bkrc_pkg::BKRC_RUN);

	// outputs, all from flip-flops
	assign pulldown_enable       = ~released_q; // see [RULE3]
	assign regulator_enable      = !parked(seq_q);
	assign output_level          = code_q; // see [RULE2]
	assign current_limit_step    = running ? `BKRC_ILIM_100 : step_q; // see [RULE7]
	assign regulation_mode       = mode_q;
	assign light_load_burst_mode = running && mode_q == bkrc_pkg::BKRC_MODE_BURST;
	assign pwm_drive_enable      = (seq_q == bkrc_pkg::BKRC_SOFT_START || running)
		&& !ovp_q && !(light_load_burst_mode && idle_q); // see [RULE10] [RULE15]
	assign high_side_hold_on     = running && mode_q == bkrc_pkg::BKRC_MODE_PASS && !ovp_q;
	assign burst_active          = light_load_burst_mode && !idle_q && !ovp_q;
	assign foldback_active       = fold_q; // see [RULE16]
	assign switch_node_tristate  = !pwm_drive_enable; // see [RULE18]
	assign active_discharge      = dis_q && running;
	assign soft_start_active     = seq_q == bkrc_pkg::BKRC_REF_WAIT || seq_q == bkrc_pkg::BKRC_SOFT_START;

endmodule

// ---- dv/bkrc_sequencer_sva.sv ----
// pin-level checker of the sequencer
// bound into every bkrc_sequencer, sees only its ports
`timescale 1ns/1ns
module bkrc_sequencer_sva #(
	parameter int unsigned CODE_W = 4
) (
	input wire logic		clock,
	input wire logic		rst_n,
	input wire logic [CODE_W-1:0]	voltage_select_code,
	input wire logic		supply_below_1v5,
	input wire logic		switch_tick,
	input wire logic		over_temperature,
	input wire logic		output_above_ovp,
	input wire logic		load_over_limit,
	input wire logic [CODE_W-1:0]	pulldown_enable,
	input wire logic		regulator_enable,
	input wire logic [3:0]		output_level,
	input wire logic [1:0]		current_limit_step,
	input wire logic		pwm_drive_enable,
	input wire logic		foldback_active,
	input wire logic		switch_node_tristate,
	input wire logic		soft_start_active
);
	logic [9:0]	tick_q, tick_d, ovl_q, ovl_d;
	logic [1:0]	step_q;
	logic		ss_q;
	// ticks since the last step change, and consecutive overloaded ticks
	always_comb begin
		tick_d = tick_q + {9'h0, switch_tick};
		if (step_q != current_limit_step || ss_q != soft_start_active) tick_d = 10'h0;
		ovl_d = load_over_limit ? ovl_q + {9'h0, switch_tick} : 10'h0;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 10'h0;
			ovl_q <= 10'h0;
			step_q <= 2'h0;
			ss_q <= 1'b0;
		end else begin
			tick_q <= tick_d;
			ovl_q <= ovl_d;
			step_q <= current_limit_step;
			ss_q <= soft_start_active;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_step_up;
		$changed(current_limit_step) && current_limit_step != 2'h0;
	endsequence
	property p_off; (voltage_select_code == 4'h0)[*4] |-> !regulator_enable && pulldown_enable == 4'hF; endproperty
	a_off: assert property (p_off) else $error("shutdown decode wrong");
	property p_level; ($stable(voltage_select_code))[*4] ##0 regulator_enable |-> output_level == voltage_select_code; endproperty
	a_level: assert property (p_level) else $error("level decode wrong");
	property p_release; ($stable(voltage_select_code) && !supply_below_1v5)[*4] |-> (pulldown_enable & voltage_select_code) == 4'h0; endproperty
	a_release: assert property (p_release) else $error("pull-down kept on");
	property p_relatch; (voltage_select_code != 4'h0 && !supply_below_1v5)[*4] |-> (pulldown_enable & ~$past(pulldown_enable)) == 4'h0; endproperty
	a_relatch: assert property (p_relatch) else $error("pull-down re-engaged");
	property p_ss; $rose(regulator_enable) |-> soft_start_active && current_limit_step == 2'h0; endproperty
	a_ss: assert property (p_ss) else $error("soft-start not begun");
	property p_step; s_step_up |-> soft_start_active && current_limit_step == $past(current_limit_step) + 2'h1; endproperty
	a_step: assert property (p_step) else $error("limit step order wrong");
	property p_step_time; s_step_up |-> (current_limit_step == 2'h1 && tick_q inside {[278:282]}) || (current_limit_step != 2'h1 && tick_q inside {[208:212]}); endproperty
	a_step_time: assert property (p_step_time) else $error("limit step timing wrong");
	property p_fold; $rose(foldback_active) |-> ovl_q inside {[32:34]}; endproperty
	a_fold: assert property (p_fold) else $error("foldback count wrong");
	property p_therm; over_temperature[*4] |-> switch_node_tristate && !pwm_drive_enable; endproperty
	a_therm: assert property (p_therm) else $error("switches on when hot");
	property p_ovp; output_above_ovp[*4] |-> !pwm_drive_enable; endproperty
	a_ovp: assert property (p_ovp) else $error("drive on in over-voltage");
endmodule
bind bkrc_sequencer bkrc_sequencer_sva #(.CODE_W(CODE_W)) u_bkrc_sequencer_sva (.*);

// ---- dv/bkrc_host_model.sv ----
// host gpio lines on the select pins
// changes on the falling clock edge, never through an all-zero code
`timescale 1ns/1ns
module bkrc_host_model (
	input  wire logic	clock,
	input  wire logic [3:0]	want_code,
	output logic [3:0]	voltage_select_code
);
	initial voltage_select_code = 4'h0;
	// disjoint codes pass through their union for one cycle
	always @(negedge clock) begin
		if (voltage_select_code != 4'h0 && want_code != 4'h0 && (voltage_select_code & want_code) == 4'h0) begin
			voltage_select_code <= voltage_select_code | want_code;
		end else begin
			voltage_select_code <= want_code;
		end
	end
endmodule

// ---- dv/test_bkrc_sequencer.sv ----
// self-checking bench of the sequencer
// host model drives the select pins, the bench the comparator levels
`timescale 1ns/1ns
module test_bkrc_sequencer;
	logic		clock = 1'b0;
	logic		rst_n = 1'b0;
	logic		en, ss, pwm, fold, tsn, llb, hold, bact, dis;
	logic [1:0]	stp, mode;
	logic [3:0]	pd, lvl, code;
	logic [3:0]	want = 4'h0;
	logic [13:0]	lv = 14'h0;
	int		div = 0, cyc = 0, fails = 0, total_checks = 0;
	int		note_id [$];
	logic [3:0]	note_q [$];
	event		chk_ev;
	string		nm [13] = '{"enable", "level", "step", "mode", "foldback", "tristate", "pulldown", "softstart",
		"pwm", "burstmode", "holdon", "burstactive", "discharge"};
	wire		tick = (div == 0);
	wire [12:0][3:0]	ob = {{3'h0, dis}, {3'h0, bact}, {3'h0, hold}, {3'h0, llb}, {3'h0, pwm}, {3'h0, ss}, pd,
		{3'h0, tsn}, {3'h0, fold}, {2'h0, mode}, {2'h0, stp}, lvl, {3'h0, en}};
	always #10 clock = ~clock;
	always @(negedge clock) div <= (div == 13) ? 0 : div + 1;
	bkrc_host_model u_bkrc_host_model (.clock(clock), .want_code(want), .voltage_select_code(code));
	bkrc_sequencer u_bkrc_sequencer (
		.clock(clock), .rst_n(rst_n), .voltage_select_code(code), .supply_below_1v5(lv[0]),
		.supply_lockout(lv[1]), .switch_tick(tick), .output_reached_90pct(lv[2]), .output_above_target(lv[11]),
		.output_above_burst_top(lv[12]), .output_below_exit(lv[3]), .output_above_ovp(lv[4]),
		.load_over_limit(lv[5]), .load_below_foldback(lv[6]), .load_below_light(lv[7]), .burst_limit_hit(lv[13]),
		.input_near_output(lv[8]), .over_temperature(lv[9]), .ccm_active(lv[10]), .pulldown_enable(pd),
		.regulator_enable(en), .output_level(lvl), .current_limit_step(stp), .regulation_mode(mode),
		.light_load_burst_mode(llb), .pwm_drive_enable(pwm), .high_side_hold_on(hold), .burst_active(bact),
		.foldback_active(fold), .switch_node_tristate(tsn), .active_discharge(dis), .soft_start_active(ss)
	);
	task automatic give_verdict;
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(int id, logic [3:0] e);
		note_id.push_back(id);
		note_q.push_back(e);
		-> chk_ev;
		#1;
	endtask
	task automatic await(int id, logic [3:0] e, int n);
		int k;
		for (k = 0; k < n && ob[id] !== e; k++) @(negedge clock);
		chk(id, e);
	endtask
	always @(chk_ev) begin
		int id;
		logic [3:0] e;
		id = note_id.pop_front();
		e = note_q.pop_front();
		total_checks++;
		if (ob[id] !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm[id], e, ob[id]);
		end
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		int c;
		logic [3:0] rel;
		c = $urandom(32'h69bdcd4e);
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		lv[0] = 1'b1;
		await(6, 4'hF, 8);
		lv[0] = 1'b0;
		lv[2] = 1'b1;
		c = $urandom_range(15, 1);
		want = c[3:0];
		await(0, 4'h1, 8);
		chk(7, 4'h1);
		chk(2, 4'h0);
		for (c = 1; c < 4; c++) await(2, c[3:0], 5000);
		await(7, 4'h0, 4000);
		chk(3, 4'h1);
		want = 4'h0;
		await(0, 4'h0, 8);
		chk(6, 4'hF);
		lv[2] = 1'b0;
		want = 4'h1;
		await(7, 4'h1, 8);
		await(7, 4'h0, 14000);
		chk(3, 4'h0);
		rel = 4'h0;
		for (c = 1; c < 16; c++) begin
			want = c[3:0];
			lv[10] = 1'($urandom);
			rel = rel | c[3:0];
			await(1, c[3:0], 12);
			chk(6, ~rel);
		end
		lv[11] = 1'b1;
		lv[10] = 1'b1;
		want = 4'h7;
		await(12, 4'h1, 8);
		chk(1, 4'h7);
		lv[11] = 1'b0;
		await(12, 4'h0, 8);
		lv[11] = 1'b1;
		lv[10] = 1'b0;
		want = 4'h3;
		await(1, 4'h3, 8);
		chk(12, 4'h0);
		lv[11] = 1'b0;
		lv[5] = 1'b1;
		repeat ($urandom_range(30, 20) * 14) @(negedge clock);
		chk(4, 4'h0);
		await(4, 4'h1, 300);
		lv[6:5] = 2'h2;
		await(4, 4'h0, 8);
		lv[6] = 1'b0;
		lv[4] = 1'b1;
		await(8, 4'h0, 8);
		lv[4] = 1'b0;
		repeat (6) @(negedge clock);
		chk(8, 4'h0);
		lv[3] = 1'b1;
		await(8, 4'h1, 8);
		lv[3] = 1'b0;
		lv[7] = 1'b1;
		await(3, 4'h1, 8);
		chk(9, 4'h1);
		chk(11, 4'h1);
		lv[7] = 1'b0;
		lv[12:11] = 2'h3;
		await(11, 4'h0, 8);
		chk(8, 4'h0);
		lv[12] = 1'b0;
		repeat (6) @(negedge clock);
		chk(11, 4'h0);
		lv[11] = 1'b0;
		await(11, 4'h1, 8);
		lv[13] = 1'b1;
		lv[11] = 1'b1;
		await(11, 4'h0, 8);
		lv[13] = 1'b0;
		lv[11] = 1'b0;
		await(11, 4'h1, 8);
		lv[3] = 1'b1;
		await(3, 4'h0, 8);
		chk(9, 4'h0);
		lv[3] = 1'b0;
		lv[8] = 1'b1;
		await(3, 4'h2, 8);
		chk(10, 4'h1);
		lv[8] = 1'b0;
		await(3, 4'h0, 8);
		chk(10, 4'h0);
		lv[1] = 1'b1;
		await(8, 4'h0, 8);
		chk(0, 4'h0);
		lv[1] = 1'b0;
		await(7, 4'h1, 8);
		lv[9] = 1'b1;
		await(0, 4'h0, 8);
		chk(5, 4'h1);
		chk(7, 4'h0);
		lv[9] = 1'b0;
		await(7, 4'h1, 12);
		give_verdict();
	end
endmodule
